// ==== design/sgc_pkg.sv ====
// Function
// (RL1) VLAN enable bit seven turns 802.1Q VLAN mode on; zero disables it.
// (RL2) Software fills the VLAN table before setting the VLAN enable bit.
// (RL3) Snoop enable bit six forwards every received IGMP packet to host port.
// (RL4) With weighted queueing off, highest non-empty queue always transmits first.
// (RL5) Weighted queueing shares bandwidth q3:q2:q1:q0 as 8:4:2:1 when all busy.
// (RL6) Each empty queue gives one extra weight to highest non-empty queue.
// (RL7) Read-only bit two shows current queue depleted its allotment; zero while rotating.
// (RL8) Sniff select one mirrors only when source and destination ports both match.
// (RL9) Sniff select zero mirrors when either source or destination port matches.
// (RL10) Bit six selects host half duplex; reset value from half-duplex strap.
// (RL11) Bit five enables host flow control; reset value from flow-control strap.
// (RL12) Bit four selects host 10 Mbps; reset value from speed strap.
// (RL13) Null VID replacement bit substitutes the 12-bit port VID for null VID.
// (RL14) Storm rate is 11 bits: high three in second register, low byte in third.
// (RL15) Storm period is 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// (RL16) Storm rate resets to 0x63 with the upper three bits zero.
// (RL17) Software keeps reserved bits at their default values.
// (RL18) Multicast storm disable selects broadcast only, or broadcast plus multicast.
// (RL19) Port counts regulated blocks per period; over limit, regulated frames drop.
// (RL20) Straps are sampled during reset; later software writes override them.
package sgc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTL_OFF = 8'h05;
	localparam logic [7:0] REG_HOST_OFF = 8'h06;
	localparam logic [7:0] REG_STORM_LO_OFF = 8'h07;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] HOST_RST = 8'h00;
	localparam logic [7:0] STORM_LO_RST = 8'h63;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam int VLAN_EN_BIT = 7;
	localparam int IGMP_EN_BIT = 6;
	localparam int WFQ_EN_BIT = 3;
	localparam int DEPL_BIT = 2;
	localparam int SNIFF_AND_BIT = 0;
	localparam int HALF_BIT = 6;
	localparam int FC_BIT = 5;
	localparam int TEN_BIT = 4;
	localparam int NULL_VID_BIT = 3;
	localparam int STORM_HI_MSB = 2;
	// ------------------------------------------------------------
	// datapath widths and constants
	// ------------------------------------------------------------
	localparam int NQ = 4;
	localparam int NUM_PORTS = 3;
	localparam int STORM_W = 11;
	localparam int VID_W = 12;
	localparam int CRED_W = 4;
	localparam logic [VID_W-1:0] NULL_VID = 12'h000;
	localparam logic [CRED_W-1:0] WFQ_W3 = 4'h8;
	localparam logic [CRED_W-1:0] WFQ_W2 = 4'h4;
	localparam logic [CRED_W-1:0] WFQ_W1 = 4'h2;
	localparam logic [CRED_W-1:0] WFQ_W0 = 4'h1;
	localparam logic [CRED_W-1:0] CRED_ONE = 4'h1;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 40000000;
	localparam longint unsigned MS_PER_S = 1000;
	localparam longint unsigned STORM_PER_100_MS = 67;
	localparam longint unsigned STORM_PER_10_MS = 500;
	localparam longint unsigned STORM_CYC_100 = STORM_PER_100_MS * CLK_HZ / MS_PER_S;
	localparam longint unsigned STORM_CYC_10 = STORM_PER_10_MS * CLK_HZ / MS_PER_S;
	localparam int TMR_W = 25;
	// configuration seen by the forwarding datapath
	typedef struct packed {
		logic vlan_en;
		logic igmp_snoop_en;
		logic wfq_en;
		logic sniff_and;
		logic host_half_duplex;
		logic host_flow_ctrl;
		logic host_10m;
		logic null_vid_replace;
		logic [STORM_W-1:0] storm_rate;
	} sgc_cfg_t;
endpackage

// ==== design/sgc_global_ctrl.sv ====
`timescale 1ns/1ps
module sgc_global_ctrl
	import sgc_pkg::*;
#(
	parameter int unsigned PERIOD_100_CYC = 32'(STORM_CYC_100),
	parameter int unsigned PERIOD_10_CYC = 32'(STORM_CYC_10),
	parameter int PORTS = NUM_PORTS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic half_duplex_strap_pin,
	input wire logic flow_control_strap_pin,
	input wire logic host_speed_strap_pin,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output sgc_cfg_t cfg,
	input wire logic igmp_rx,
	output logic igmp_to_host,
	input wire logic sniff_req,
	input wire logic src_match,
	input wire logic dst_match,
	output logic mirror,
	input wire logic vid_valid,
	input wire logic [VID_W-1:0] vid_in,
	input wire logic [VID_W-1:0] port_vid,
	output logic [VID_W-1:0] vid_out,
	output logic vid_out_valid,
	input wire logic [NQ-1:0] q_nonempty,
	input wire logic tx_done,
	output logic [1:0] tx_sel,
	output logic tx_sel_valid,
	input wire logic mcast_storm_off,
	input wire logic [PORTS-1:0] port_10m,
	input wire logic [PORTS-1:0] frm_start,
	input wire logic [PORTS-1:0] frm_end,
	input wire logic [PORTS-1:0] frm_bcast,
	input wire logic [PORTS-1:0] frm_mcast,
	input wire logic [PORTS-1:0] blk_tick,
	output logic [PORTS-1:0] storm_drop
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// per-round allotment; empty queues pass one unit each to the top busy queue
	function automatic logic [NQ-1:0][CRED_W-1:0] wfq_weights(input logic [NQ-1:0] ne);
		logic [NQ-1:0][CRED_W-1:0] w;
		logic [CRED_W-1:0] extra;
		logic placed;
		w = '0;
		extra = '0;
		placed = 1'b0;
		w[3] = ne[3] ? WFQ_W3 : '0; // RL5
		w[2] = ne[2] ? WFQ_W2 : '0;
		w[1] = ne[1] ? WFQ_W1 : '0;
		w[0] = ne[0] ? WFQ_W0 : '0;
		for (int i = 0; i < NQ; i++)
		begin
			if (!ne[i])
				extra = extra + CRED_ONE;
		end
		for (int i = NQ - 1; i >= 0; i--)
		begin
			if (ne[i] && !placed)
			begin
				w[i] = w[i] + extra; // RL6
				placed = 1'b1;
			end
		end
		return w;
	endfunction

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] ctl_ff, nxt_ctl;
	logic [7:0] host_ff, nxt_host;
	logic [7:0] storm_lo_ff, nxt_storm_lo;
	logic [7:0] rdata_ff, nxt_rdata;
	logic depl_ff;
	logic wr_ctl, wr_host, wr_lo;

	assign wr_ctl = reg_wr && (reg_addr == REG_CTL_OFF);
	assign wr_host = reg_wr && (reg_addr == REG_HOST_OFF);
	assign wr_lo = reg_wr && (reg_addr == REG_STORM_LO_OFF);

	// writes store the whole byte; the depleted bit is status and never stored
	always_comb
	begin
		nxt_ctl = ctl_ff;
		nxt_host = host_ff;
		nxt_storm_lo = storm_lo_ff;
		nxt_rdata = rdata_ff;
		if (wr_ctl)
		begin
			nxt_ctl = reg_wdata;
			nxt_ctl[DEPL_BIT] = 1'b0;
		end
		if (wr_host)
			nxt_host = reg_wdata; // RL20
		if (wr_lo)
			nxt_storm_lo = reg_wdata;
		if (reg_rd)
		begin
			unique case (reg_addr)
				REG_CTL_OFF:
				begin
					nxt_rdata = ctl_ff;
					nxt_rdata[DEPL_BIT] = depl_ff; // RL7
				end
				REG_HOST_OFF: nxt_rdata = host_ff;
				REG_STORM_LO_OFF: nxt_rdata = storm_lo_ff;
				default: nxt_rdata = UNMAPPED_RD;
			endcase
		end
	end

	// synchronous reset, so the straps can be caught while rst_n is held low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctl_ff <= CTL_RST;
			host_ff <= HOST_RST;
			host_ff[HALF_BIT] <= half_duplex_strap_pin; // RL10 RL20
			host_ff[FC_BIT] <= flow_control_strap_pin; // RL11
			host_ff[TEN_BIT] <= host_speed_strap_pin; // RL12
			storm_lo_ff <= STORM_LO_RST; // RL16
			rdata_ff <= UNMAPPED_RD;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
			host_ff <= nxt_host;
			storm_lo_ff <= nxt_storm_lo;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// configuration fields straight from the register flops
	always_comb
	begin
		cfg.vlan_en = ctl_ff[VLAN_EN_BIT]; // RL1
		cfg.igmp_snoop_en = ctl_ff[IGMP_EN_BIT];
		cfg.wfq_en = ctl_ff[WFQ_EN_BIT];
		cfg.sniff_and = ctl_ff[SNIFF_AND_BIT];
		cfg.host_half_duplex = host_ff[HALF_BIT];
		cfg.host_flow_ctrl = host_ff[FC_BIT];
		cfg.host_10m = host_ff[TEN_BIT];
		cfg.null_vid_replace = host_ff[NULL_VID_BIT];
		cfg.storm_rate = {host_ff[STORM_HI_MSB:0], storm_lo_ff}; // RL14
	end

	// ------------------------------------------------------------
	// per-packet decisions
	// ------------------------------------------------------------
	logic igmp_ff, nxt_igmp;
	logic mirror_ff, nxt_mirror;
	logic [VID_W-1:0] vid_ff, nxt_vid;
	logic vid_v_ff, nxt_vid_v;

	// each decision lands one cycle after its request
	always_comb
	begin
		nxt_igmp = igmp_rx && cfg.igmp_snoop_en; // RL3
		nxt_mirror = 1'b0;
		if (sniff_req)
		begin
			if (cfg.sniff_and)
				nxt_mirror = src_match && dst_match; // RL8
			else
				nxt_mirror = src_match || dst_match; // RL9
		end
		nxt_vid_v = vid_valid;
		nxt_vid = vid_ff;
		if (vid_valid)
		begin
			if (cfg.null_vid_replace && (vid_in == NULL_VID))
				nxt_vid = port_vid; // RL13
			else
				nxt_vid = vid_in;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			igmp_ff <= 1'b0;
			mirror_ff <= 1'b0;
			vid_ff <= NULL_VID;
			vid_v_ff <= 1'b0;
		end
		else
		begin
			igmp_ff <= nxt_igmp;
			mirror_ff <= nxt_mirror;
			vid_ff <= nxt_vid;
			vid_v_ff <= nxt_vid_v;
		end
	end

	assign igmp_to_host = igmp_ff;
	assign mirror = mirror_ff;
	assign vid_out = vid_ff;
	assign vid_out_valid = vid_v_ff;

	// ------------------------------------------------------------
	// egress scheduler
	// ------------------------------------------------------------
	logic [NQ-1:0][CRED_W-1:0] cred_ff, nxt_cred;
	logic [1:0] sel_ff, nxt_sel;
	logic sel_v_ff, nxt_sel_v;
	logic nxt_depl;
	logic [NQ-1:0] elig;
	logic found;
	logic [1:0] pick;
	logic lower_left;

	// pick the top eligible queue; when every busy queue is out of credit a new
	// round is loaded and the grant drops for that one cycle
	always_comb
	begin
		nxt_cred = cred_ff;
		nxt_depl = depl_ff;
		found = 1'b0;
		pick = '0;
		lower_left = 1'b0;
		for (int i = 0; i < NQ; i++)
			elig[i] = q_nonempty[i] && (!cfg.wfq_en || (cred_ff[i] != '0));
		for (int i = NQ - 1; i >= 0; i--)
		begin
			if (elig[i] && !found)
			begin
				found = 1'b1; // RL4
				pick = 2'(i);
			end
		end
		if (!cfg.wfq_en)
		begin
			nxt_depl = 1'b0;
			nxt_cred = '0;
		end
		else if (tx_done && sel_v_ff && (cred_ff[sel_ff] != '0))
		begin
			nxt_cred[sel_ff] = cred_ff[sel_ff] - CRED_ONE;
			for (int i = 0; i < NQ; i++)
			begin
				if ((2'(i) < sel_ff) && elig[i])
					lower_left = 1'b1;
			end
			if ((cred_ff[sel_ff] == CRED_ONE) && lower_left)
				nxt_depl = 1'b1; // RL7
		end
		else if (!found && (q_nonempty != '0))
		begin
			nxt_cred = wfq_weights(q_nonempty); // RL5 RL6
			nxt_depl = 1'b0; // RL7
		end
		nxt_sel = found ? pick : sel_ff;
		nxt_sel_v = found;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cred_ff <= '0;
			sel_ff <= '0;
			sel_v_ff <= 1'b0;
			depl_ff <= 1'b0;
		end
		else
		begin
			cred_ff <= nxt_cred;
			sel_ff <= nxt_sel;
			sel_v_ff <= nxt_sel_v;
			depl_ff <= nxt_depl;
		end
	end

	assign tx_sel = sel_ff;
	assign tx_sel_valid = sel_v_ff;

	// ------------------------------------------------------------
	// broadcast storm protection
	// ------------------------------------------------------------
	logic [PORTS-1:0][TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [PORTS-1:0][STORM_W-1:0] cnt_ff, nxt_cnt;
	logic [PORTS-1:0] infrm_ff, nxt_infrm;
	logic [PORTS-1:0] drop_ff, nxt_drop;
	logic [PORTS-1:0] per_end;
	logic [PORTS-1:0] regulated;
	logic [TMR_W-1:0] per_last [PORTS];

	// the counter clears at the period edge but a block in that same cycle
	// still counts, so no data slips past the limit
	always_comb
	begin
		nxt_tmr = tmr_ff;
		nxt_cnt = cnt_ff;
		nxt_infrm = infrm_ff;
		nxt_drop = '0;
		for (int p = 0; p < PORTS; p++)
		begin
			per_last[p] = port_10m[p] ? TMR_W'(PERIOD_10_CYC - 1) :
				TMR_W'(PERIOD_100_CYC - 1); // RL15
			per_end[p] = (tmr_ff[p] >= per_last[p]);
			nxt_tmr[p] = per_end[p] ? '0 : tmr_ff[p] + 1'b1;
			regulated[p] = frm_bcast[p] || (frm_mcast[p] && !mcast_storm_off); // RL18
			if (per_end[p])
				nxt_cnt[p] = '0; // RL19
			if (blk_tick[p] && infrm_ff[p] && (nxt_cnt[p] != '1))
				nxt_cnt[p] = nxt_cnt[p] + 1'b1; // RL19
			if (frm_end[p])
				nxt_infrm[p] = 1'b0;
			if (frm_start[p] && regulated[p])
			begin
				if (cnt_ff[p] >= cfg.storm_rate)
				begin
					nxt_drop[p] = 1'b1; // RL19
					nxt_infrm[p] = 1'b0;
				end
				else
					nxt_infrm[p] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tmr_ff <= '0;
			cnt_ff <= '0;
			infrm_ff <= '0;
			drop_ff <= '0;
		end
		else
		begin
			tmr_ff <= nxt_tmr;
			cnt_ff <= nxt_cnt;
			infrm_ff <= nxt_infrm;
			drop_ff <= nxt_drop;
		end
	end

	assign storm_drop = drop_ff;
endmodule

// ==== verif/sgc_checker.sv ====
`timescale 1ns/1ps
// ----
// port checker
// ----
module sgc_checker
	import sgc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire sgc_cfg_t cfg,
	input wire logic igmp_rx,
	input wire logic igmp_to_host,
	input wire logic sniff_req,
	input wire logic src_match,
	input wire logic dst_match,
	input wire logic mirror,
	input wire logic vid_valid,
	input wire logic [VID_W-1:0] vid_in,
	input wire logic [VID_W-1:0] port_vid,
	input wire logic [VID_W-1:0] vid_out,
	input wire logic [NQ-1:0] q_nonempty,
	input wire logic [1:0] tx_sel,
	input wire logic tx_sel_valid
);
	// one domain, so clock and reset are stated once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_vlan;
		reg_wr && reg_addr == REG_CTL_OFF |=> cfg.vlan_en == $past(reg_wdata[VLAN_EN_BIT]);
	endproperty
	a_vlan: assert property (p_vlan) else $error("vlan enable not stored");
	property p_igmp;
		igmp_rx |=> igmp_to_host == $past(cfg.igmp_snoop_en);
	endproperty
	a_igmp: assert property (p_igmp) else $error("igmp forward wrong");
	property p_and;
		sniff_req && cfg.sniff_and |=> mirror == $past(src_match && dst_match);
	endproperty
	a_and: assert property (p_and) else $error("and sniff wrong");
	property p_or;
		sniff_req && !cfg.sniff_and |=> mirror == $past(src_match || dst_match);
	endproperty
	a_or: assert property (p_or) else $error("or sniff wrong");
	property p_vid;
		vid_valid && cfg.null_vid_replace && vid_in == NULL_VID |=> vid_out == $past(port_vid);
	endproperty
	a_vid: assert property (p_vid) else $error("null id not replaced");
	property p_keep;
		vid_valid && !cfg.null_vid_replace |=> vid_out == $past(vid_in);
	endproperty
	a_keep: assert property (p_keep) else $error("id changed");
	property p_strict;
		!cfg.wfq_en && q_nonempty[3] |=> tx_sel_valid && tx_sel == 2'h3;
	endproperty
	a_strict: assert property (p_strict) else $error("top queue not first");
	property p_idle;
		q_nonempty == 4'h0 |=> !tx_sel_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("select with no queue");
endmodule
bind sgc_global_ctrl sgc_checker sgc_checker_inst (
	.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .cfg, .igmp_rx, .igmp_to_host, .sniff_req,
	.src_match, .dst_match, .mirror, .vid_valid, .vid_in, .port_vid, .vid_out, .q_nonempty,
	.tx_sel, .tx_sel_valid);

// ==== verif/switch_global_control_3_to_5_test.sv ====
`timescale 1ns/1ps
module switch_global_control_3_to_5_test;
	import sgc_pkg::*;
	// ----
	// bench
	// ----
	logic clk, rst_n, half_duplex_strap_pin, flow_control_strap_pin, host_speed_strap_pin;
	logic reg_wr, reg_rd, igmp_rx, sniff_req, src_match, dst_match, vid_valid, tx_done;
	logic mcast_storm_off, mirror, igmp_to_host, vid_out_valid, tx_sel_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [VID_W-1:0] vid_in, port_vid, vid_out;
	logic [NQ-1:0] q_nonempty;
	logic [1:0] tx_sel;
	logic [2:0] port_10m, frm_start, frm_end, frm_bcast, frm_mcast, blk_tick, storm_drop;
	sgc_cfg_t cfg;
	int bad_count, compares;
	// short periods keep the storm window inside the run
	localparam int unsigned P100 = 2000;
	localparam int unsigned P10 = 5000;
	sgc_global_ctrl #(.PERIOD_100_CYC(P100), .PERIOD_10_CYC(P10)) sgc_global_ctrl_inst (
		.clk, .rst_n, .half_duplex_strap_pin, .flow_control_strap_pin, .host_speed_strap_pin,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cfg, .igmp_rx, .igmp_to_host,
		.sniff_req, .src_match, .dst_match, .mirror, .vid_valid, .vid_in, .port_vid, .vid_out,
		.vid_out_valid, .q_nonempty, .tx_done, .tx_sel, .tx_sel_valid, .mcast_storm_off,
		.port_10m, .frm_start, .frm_end, .frm_bcast, .frm_mcast, .blk_tick, .storm_drop);
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// verdict and comparison helpers
	task automatic final_report();
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string n, input logic [15:0] s, e);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// register strobes, driven at the falling edge
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check("reg_rdata", 16'(reg_rdata), 16'(e));
	endtask
	// one frame on port 0, one block long
	task automatic frame(input logic b, m, e);
		@(negedge clk);
		frm_start = 3'h1;
		frm_bcast = {2'h0, b};
		frm_mcast = {2'h0, m};
		@(negedge clk);
		frm_start = 3'h0;
		blk_tick = 3'h1;
		check("storm_drop", 16'(storm_drop), {15'h0, e});
		@(negedge clk);
		blk_tick = 3'h0;
		frm_end = 3'h1;
		@(negedge clk);
		frm_end = 3'h0;
	endtask
	task automatic sn(input logic i, s, d, ei, em);
		@(negedge clk);
		igmp_rx = i;
		sniff_req = 1'b1;
		src_match = s;
		dst_match = d;
		@(negedge clk);
		igmp_rx = 1'b0;
		sniff_req = 1'b0;
		check("igmp_to_host", 16'(igmp_to_host), 16'(ei));
		check("mirror", 16'(mirror), 16'(em));
	endtask
	task automatic vt(input logic [VID_W-1:0] v, e);
		@(negedge clk);
		vid_valid = 1'b1;
		vid_in = v;
		@(negedge clk);
		vid_valid = 1'b0;
		check("vid_out", 16'({vid_out_valid, vid_out}), 16'({1'b1, e}));
	endtask
	// scenarios
	task automatic t_storm();
		wr(REG_HOST_OFF, 8'h00);
		wr(REG_STORM_LO_OFF, 8'h00);
		frame(1'b1, 1'b0, 1'b1);
		frame(1'b0, 1'b0, 1'b0);
		frame(1'b0, 1'b1, 1'b1);
		mcast_storm_off = 1'b1;
		frame(1'b0, 1'b1, 1'b0);
		wr(REG_STORM_LO_OFF, 8'h01);
		frame(1'b1, 1'b0, 1'b0);
		frame(1'b1, 1'b0, 1'b1);
		// one full 100 Mbps period always holds a period end, so the count is clear
		repeat (P100) @(negedge clk);
		port_10m = 3'h1;
		frame(1'b1, 1'b0, 1'b0);
		frame(1'b1, 1'b0, 1'b1);
		// timer is below the short period here, so the long one cannot end yet
		repeat (P100) @(negedge clk);
		frame(1'b1, 1'b0, 1'b1);
		repeat (P10) @(negedge clk);
		frame(1'b1, 1'b0, 1'b0);
		port_10m = 3'h0;
		wr(REG_HOST_OFF, 8'h07);
		check("storm_rate", 16'(cfg.storm_rate), 16'h0701);
	endtask
	task automatic t_reset();
		rd(REG_CTL_OFF, CTL_RST);
		rd(REG_HOST_OFF, 8'h50);
		rd(REG_STORM_LO_OFF, STORM_LO_RST);
		rd(8'h08, UNMAPPED_RD);
		wr(REG_HOST_OFF, 8'h20);
		rd(REG_HOST_OFF, 8'h20);
	endtask
	task automatic t_ctl();
		// reserved bits stay zero; the vlan table lives outside this block
		wr(REG_CTL_OFF, 8'hcd);
		rd(REG_CTL_OFF, 8'hc9);
		check("cfg", 16'({cfg.vlan_en, cfg.igmp_snoop_en, cfg.wfq_en, cfg.sniff_and}), 16'hf);
		wr(8'h08, 8'h55);
		rd(8'h08, UNMAPPED_RD);
	endtask
	task automatic t_pkt();
		wr(REG_CTL_OFF, 8'h40);
		sn(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		sn(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		wr(REG_CTL_OFF, 8'h01);
		sn(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		sn(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		wr(REG_HOST_OFF, 8'h08);
		vt(12'h000, 12'h5a5);
		vt(12'h123, 12'h123);
		wr(REG_HOST_OFF, 8'h00);
		vt(12'h000, 12'h000);
	endtask
	task automatic t_sched();
		wr(REG_CTL_OFF, 8'h00);
		q_nonempty = 4'hc;
		repeat (2) @(negedge clk);
		check("tx_sel", 16'({tx_sel_valid, tx_sel}), 16'h7);
		q_nonempty = 4'h1;
		repeat (2) @(negedge clk);
		check("tx_sel", 16'({tx_sel_valid, tx_sel}), 16'h4);
		q_nonempty = 4'h0;
		wr(REG_CTL_OFF, 8'h08);
		q_nonempty = 4'hf;
		repeat (2) @(negedge clk);
		drain(8, 16'h6);
		rd(REG_CTL_OFF, 8'h0c);
		wr(REG_CTL_OFF, 8'h00);
		rd(REG_CTL_OFF, 8'h00);
		q_nonempty = 4'h0;
		// q2 empty: its unit goes to q3, nine sends before q1 is served
		wr(REG_CTL_OFF, 8'h08);
		q_nonempty = 4'hb;
		repeat (2) @(negedge clk);
		drain(9, 16'h5);
		rd(REG_CTL_OFF, 8'h0c);
		q_nonempty = 4'h0;
		wr(REG_CTL_OFF, 8'h00);
	endtask
	// n sends from queue 3, then the next grant is compared
	task automatic drain(input int n, input logic [15:0] e);
		for (int i = 0; i < n; i++)
		begin
			check("tx_sel", 16'({tx_sel_valid, tx_sel}), 16'h7);
			tx_done = 1'b1;
			@(negedge clk);
		end
		tx_done = 1'b0;
		@(negedge clk);
		check("tx_sel", 16'({tx_sel_valid, tx_sel}), e);
	endtask
	// second reset in mid-run with other strap levels
	task automatic t_rerst();
		wr(REG_CTL_OFF, 8'hc1);
		rd(REG_CTL_OFF, 8'hc1);
		rst_n = 1'b0;
		{half_duplex_strap_pin, flow_control_strap_pin, host_speed_strap_pin} = 3'b011;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		{half_duplex_strap_pin, flow_control_strap_pin, host_speed_strap_pin} = 3'b100;
		check("reg_rdata", 16'(reg_rdata), 16'(UNMAPPED_RD));
		check("tx_sel", 16'({tx_sel_valid, tx_sel}), 16'h0);
		check("vlan_en", 16'(cfg.vlan_en), 16'h0);
		rd(REG_CTL_OFF, CTL_RST);
		rd(REG_HOST_OFF, 8'h30);
		rd(REG_STORM_LO_OFF, STORM_LO_RST);
		check("storm_rate", 16'(cfg.storm_rate), 16'h0063);
	endtask
	// main sequence; straps change after release and must not leak in
	initial
	begin
		{rst_n, reg_wr, reg_rd, igmp_rx, sniff_req, src_match, dst_match, vid_valid} = '0;
		{tx_done, mcast_storm_off, port_10m, frm_start, frm_end, frm_bcast} = '0;
		{frm_mcast, blk_tick, reg_addr, reg_wdata, vid_in, q_nonempty} = '0;
		{half_duplex_strap_pin, flow_control_strap_pin, host_speed_strap_pin} = 3'b101;
		port_vid = 12'h5a5;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		{half_duplex_strap_pin, flow_control_strap_pin, host_speed_strap_pin} = 3'b010;
		t_reset();
		t_storm();
		t_ctl();
		t_pkt();
		t_sched();
		t_rerst();
		final_report();
	end
	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule
